// ==== bench/echo_canceller_pin_control_tb_top.sv ====
/*
 bench top: split and shared pairs on one apb bus, strap, microport and standby tests.
 assumes the package and link interface are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module echo_canceller_pin_control_tb_top import ecpc_pkg::*;;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, prdata2, rd, rd2;
   logic pready, pready2, pslverr, pslverr2, err;
   logic tone_det_a = 1'b0;
   logic tone_det_b = 1'b0;
   logic ctl_mode, standby, supp_en, ph_strict, alaw_sel, itu_code;
   ecpc_fstate_t state_a, state_b;
   logic [9:0] obs;
   logic [10:0] straps [4] = '{11'h041, 11'h4d5, 11'h36a, 11'h7ff};
   int num_errors = 0;
   int check_count = 0;
   ecpc_link_if link ();
   ecpc_link_if link2 ();
   assign obs = {ctl_mode, standby, supp_en, ph_strict, alaw_sel, itu_code, state_a, state_b};
   always #5 pclk = ~pclk;
   ecpc_host #(.SHARED_DATA(1'b0)) ecpc_host_inst (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   ecpc_dev #(.SHARED_DATA(1'b0)) ecpc_dev_inst (.pclk(pclk), .presetn(presetn), .link(link),
      .tone_det_a(tone_det_a), .tone_det_b(tone_det_b), .ctl_mode(ctl_mode), .standby(standby),
      .suppressor_en(supp_en), .phase_strict(ph_strict), .alaw_sel(alaw_sel), .itu_code(itu_code),
      .state_a(state_a), .state_b(state_b));
   // shared-data pair shares the bus; its ready, error, busy bit and read data are judged
   ecpc_host #(.SHARED_DATA(1'b1)) ecpc_host_shr_inst (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata2), .pready(pready2), .pslverr(pslverr2), .link(link2));
   ecpc_dev #(.SHARED_DATA(1'b1)) ecpc_dev_shr_inst (.pclk(pclk), .presetn(presetn), .link(link2),
      .tone_det_a(tone_det_a), .tone_det_b(tone_det_b), .ctl_mode(), .standby(), .suppressor_en(),
      .phase_strict(), .alaw_sel(), .itu_code(), .state_a(), .state_b());
   ecpc_sva ecpc_sva_inst (.pclk(pclk), .presetn(presetn),
      .cfg_strap_one(link.cfg_strap_one), .cfg_strap_two(link.cfg_strap_two),
      .standby_n(link.standby_n), .tone_flag_a_n(link.tone_flag_a_n), .tone_flag_b_n(link.tone_flag_b_n),
      .state_sel_b_hi(link.state_sel_b_hi), .state_sel_b_lo(link.state_sel_b_lo),
      .state_sel_a_hi(link.state_sel_a_hi), .host_io_oe_n(link.host_io_oe_n),
      .dev_io_oe_n(link.dev_io_oe_n));
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      rd2 = prdata2;
      err = pslverr;
      chk("apb pair answer", {30'h0, 1'b1, err}, {30'h0, pready2, pslverr2});
      chk("apb handshake", 32'h0, {31'h0, n >= 50});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // one microport frame; read data lands in rd and rd2 bits 15:8
   task automatic mp(input logic r, input logic [6:0] a, input logic [7:0] d);
      int n;
      n = 0;
      apb(1'b1, ECPC_APB_CMD, {16'h0000, r, a, d});
      rd = 32'h1;
      while ((rd[0] | rd2[0]) !== 1'b0 && n < 200) begin
         apb(1'b0, ECPC_APB_STAT, 32'h0);
         n++;
      end
      chk("microport busy", 32'h0, {31'h0, n >= 200});
   endtask
   task automatic tone(input logic a, input logic b);
      tone_det_a <= a;
      tone_det_b <= b;
      repeat (4) @(posedge pclk);
      chk("tone flags", {30'h0, !a, !b}, {30'h0, link.tone_flag_a_n, link.tone_flag_b_n});
      apb(1'b0, ECPC_APB_STAT, 32'h0);
      chk("tone status", {30'h0, b, a}, {30'h0, rd[17:16]});
   endtask
   task automatic strap(input logic [10:0] s, input logic [9:0] exp);
      apb(1'b1, ECPC_APB_STRAP, {21'h0, s});
      repeat (12) @(posedge pclk);
      chk("pin decode", {22'h0, exp}, {22'h0, obs});
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (50000) @(posedge pclk);
      num_errors++;
      end_of_test();
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (straps[i]) begin
         strap(straps[i], {2'b00, straps[i][2], straps[i][3], straps[i][4], straps[i][5], straps[i][9],
            straps[i][10], straps[i][7], straps[i][8]});
      end
      tone(1'b1, 1'b0);
      tone(1'b0, 1'b1);
      tone(1'b0, 1'b0);
      apb(1'b0, 12'h00c, 32'h0);
      chk("apb unmapped error", 32'h1, {31'h0, err});
      chk("apb unmapped data", 32'h0, rd);
      $display("test strap done");
      strap(11'h07c, 10'b1011110000);
      mp(1'b0, ECPC_REG_CTRL2, 8'h01);
      strap(11'h07c, 10'b1001110000);
      mp(1'b0, ECPC_REG_CTRL2, 8'h02);
      strap(11'h07c, 10'b1010110000);
      mp(1'b0, ECPC_REG_STATE, 8'h0e);
      strap(11'h07c, 10'b1010111011);
      mp(1'b1, ECPC_REG_STATE, 8'h00);
      chk("split read", 32'h0e, {24'h0, rd[15:8]});
      chk("shared read", 32'h0e, {24'h0, rd2[15:8]});
      tone(1'b1, 1'b0);
      mp(0, ECPC_REG_STATUS, 8'hff);
      mp(1'b1, ECPC_REG_STATUS, 8'h00);
      chk("status read", 32'h01, {24'h0, rd[15:8]});
      tone(1'b0, 1'b1);
      mp(1'b1, 7'h7f, 8'h00);
      chk("unmapped micro read", 32'h00, {24'h0, rd[15:8]});
      $display("test controller done");
      tone_det_a <= 1'b1;
      tone_det_b <= 1'b1;
      strap(11'h03c, 10'b0100000000);
      chk("standby flags", 32'h3, {30'h0, link.tone_flag_a_n, link.tone_flag_b_n});
      tone_det_a <= 1'b0;
      tone_det_b <= 1'b0;
      strap(11'h07c, 10'b1011110000);
      $display("test standby done");
      end_of_test();
   end
endmodule // echo_canceller_pin_control_tb_top
`default_nettype wire

// ==== bench/ecpc_sva.sv ====
/*
 link checker: microport framing, io ownership and standby flag level.
 assumes the link signals of the split-data pair and one pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ecpc_sva #(
   parameter int SCLK_HALF = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cfg_strap_one,
   input wire logic cfg_strap_two,
   input wire logic standby_n,
   input wire logic tone_flag_a_n,
   input wire logic tone_flag_b_n,
   input wire logic state_sel_b_hi,
   input wire logic state_sel_b_lo,
   input wire logic state_sel_a_hi,
   input wire logic host_io_oe_n,
   input wire logic dev_io_oe_n
);
   logic ctl;
   logic sclk_q;
   logic [4:0] rises;
   logic [7:0] hi_cnt;
   assign ctl = !cfg_strap_one && !cfg_strap_two;
   // counters let long spans be checked without long repetitions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q <= 1'b0;
         rises <= 5'h00;
         hi_cnt <= 8'h00;
      end else begin
         sclk_q <= state_sel_b_hi;
         hi_cnt <= state_sel_b_hi ? hi_cnt + 8'h01 : 8'h00;
         if (state_sel_b_lo) begin
            rises <= 5'h00;
         end else if (state_sel_b_hi && !sclk_q) begin
            rises <= rises + 5'h01;
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence bit_rise;
      ctl && !state_sel_b_lo && $rose(state_sel_b_hi);
   endsequence
   sequence frame_end;
      ctl && $rose(state_sel_b_lo);
   endsequence
   a_frame_bits: assert property (frame_end |-> rises == 5'h10)
      else $error("frame did not carry sixteen clocks");
   a_sclk_idle: assert property (ctl && state_sel_b_lo |-> !state_sel_b_hi)
      else $error("serial clock moved outside a frame");
   a_sclk_high: assert property (ctl && $past(ctl) && $fell(state_sel_b_hi) |-> hi_cnt == SCLK_HALF)
      else $error("serial clock high time wrong");
   a_rx_stable: assert property (bit_rise |-> $stable(state_sel_a_hi))
      else $error("rx data moved at the clock rise");
   a_host_no_drive: assert property (ctl && $past(ctl) |-> host_io_oe_n)
      else $error("host drove io in split mode");
   a_io_release: assert property (frame_end |-> ##[1:8] dev_io_oe_n)
      else $error("device kept io after select rose");
   a_io_ctl_only: assert property (!dev_io_oe_n |-> ctl)
      else $error("device drove io outside controller mode");
   a_standby_flags: assert property (!standby_n [*8] |-> tone_flag_a_n && tone_flag_b_n)
      else $error("tone flag low in standby");
endmodule // ecpc_sva
`default_nettype wire

// ==== core/ecpc_dev.sv ====
/*
 device end: strap decode, controller mode pin reuse, serial microport slave,
 tone flag drive.
 assumes pclk 100 mhz, tone_det_a/b are same-clock levels from the tone detectors
 that already include their release hold, and sclk half periods of at least 6 pclk.
 frame: 8 command bits (read flag, 7 bit address) then 8 data bits, msb first.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// - strap mode: suppressor pin high enables suppressors
// - strap mode: suppressor pin low disables suppressors
// - controller mode: suppressor from control register bit
// - phase pin high: only phase-reversed tone triggers
// - phase pin low: any disable tone triggers
// - controller mode: phase check from register bit
// - law pin low mu-law, high a-law
// - style pin low sign-magnitude, high standard
// - standby low holds reset and low power
// - canceller b tone drives flag b low
// - canceller a tone drives flag a low
// - flags rise after release, same both modes
// - strap mode: b selects set canceller b state
// - strap mode: a selects set canceller a state
// - controller mode: b selects become clock, select
// - controller mode: a selects become rx, io
// - transfers only while select is low
// - host clock is the microport bit clock
// - split variant receives on rx line
// - split variant uses io only to send
// - shared variant io turns around for reads
// - controller mode only when both straps zero
// - four functional states per canceller
module ecpc_dev import ecpc_pkg::*; #(
   parameter bit SHARED_DATA = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   ecpc_link_if.dev link,
   input wire logic tone_det_a,
   input wire logic tone_det_b,
   output logic ctl_mode,
   output logic standby,
   output logic suppressor_en,
   output logic phase_strict,
   output logic alaw_sel,
   output logic itu_code,
   output ecpc_fstate_t state_a,
   output ecpc_fstate_t state_b
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [ECPC_SB_W-1:0] pins;
   logic [ECPC_SB_W-1:0] sy;
   assign pins = {link.state_sel_a_lo, link.state_sel_a_hi, link.state_sel_b_lo,
                  link.state_sel_b_hi, link.standby_n, link.code_style, link.law_sel,
                  link.tone_phase_strict, link.suppressor_ctl, link.cfg_strap_two,
                  link.cfg_strap_one};
   ecpc_sync #(.W(ECPC_SB_W)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(pins),
      .q(sy)
   );
   // ****************************************
   // state
   // ****************************************
   ecpc_dev_st_t r;
   ecpc_dev_st_t next_r;
   logic din;
   logic rise;
   logic fall;
   logic [7:0] rdv;
   logic [7:0] wd;
   function automatic logic [7:0] rd_reg(input logic [6:0] a, input ecpc_dev_st_t s);
      rd_reg = 8'h00;
      if (a == ECPC_REG_STATE) begin
         rd_reg = {4'h0, s.reg_b, s.reg_a};
      end else if (a == ECPC_REG_STATUS) begin
         rd_reg = {6'h00, ~s.flag_b_n, ~s.flag_a_n};
      end else if (a == ECPC_REG_CTRL2) begin
         rd_reg = {6'h00, s.phase_off, s.supp_off};
      end
   endfunction
   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_r = r;
      // split variant samples rx, shared samples the io pin
      din = SHARED_DATA ? sy[ECPC_SB_A_LO] : sy[ECPC_SB_A_HI];
      rise = sy[ECPC_SB_B_HI] & ~r.sclk_q;
      fall = ~sy[ECPC_SB_B_HI] & r.sclk_q;
      rdv = rd_reg(r.cmd[6:0], r);
      wd = {r.wsh[6:0], din};
      next_r.sclk_q = sy[ECPC_SB_B_HI];
      next_r.stby = 1'b0;
      next_r.ctl = ~sy[ECPC_SB_CFG1] & ~sy[ECPC_SB_CFG2];
      if (r.ctl) begin
         next_r.supp = ~r.supp_off;
         next_r.phase = ~r.phase_off;
         next_r.sa = r.reg_a;
         next_r.sb = r.reg_b;
      end else begin
         next_r.supp = sy[ECPC_SB_SUPP];
         next_r.phase = sy[ECPC_SB_PHASE];
         next_r.sa = {sy[ECPC_SB_A_HI], sy[ECPC_SB_A_LO]};
         next_r.sb = {sy[ECPC_SB_B_HI], sy[ECPC_SB_B_LO]};
      end
      next_r.alaw = sy[ECPC_SB_LAW];
      next_r.itu = sy[ECPC_SB_STYLE];
      // detectors hold their level until release, so no mode term here
      next_r.flag_a_n = ~tone_det_a;
      next_r.flag_b_n = ~tone_det_b;
      if (!r.ctl || sy[ECPC_SB_B_LO]) begin
         // select high aborts any frame and frees the io pin
         next_r.cnt = 5'h00;
         next_r.io_oe_n = 1'b1;
      end else if (rise && r.cnt != ECPC_FRAME_BITS) begin
         if (r.cnt < ECPC_CMD_BITS) begin
            next_r.cmd = {r.cmd[6:0], din};
         end else if (!r.cmd[7]) begin
            next_r.wsh = wd;
            if (r.cnt == ECPC_FRAME_BITS - 5'h01) begin
               if (r.cmd[6:0] == ECPC_REG_STATE) begin
                  next_r.reg_a = wd[1:0];
                  next_r.reg_b = wd[3:2];
               end else if (r.cmd[6:0] == ECPC_REG_CTRL2) begin
                  next_r.supp_off = wd[ECPC_CTRL2_SUPP_OFF];
                  next_r.phase_off = wd[ECPC_CTRL2_PHASE_OFF];
               end
            end
         end
         next_r.cnt = r.cnt + 5'h01;
      end else if (fall && r.cmd[7] && r.cnt >= ECPC_CMD_BITS && r.cnt != ECPC_FRAME_BITS) begin
         // read data leaves on falling sclk so the host samples a settled bit
         next_r.io_oe_n = 1'b0;
         next_r.io_o = rdv[~r.cnt[2:0]];
      end else if (fall && r.cnt == ECPC_FRAME_BITS) begin
         next_r.io_oe_n = 1'b1;
      end
      if (!sy[ECPC_SB_STBY]) begin
         next_r = ECPC_DEV_RESET;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= ECPC_DEV_RESET;
      end else begin
         r <= next_r;
      end
   end
   // ****************************************
   // outputs
   // ****************************************
   assign link.tone_flag_a_n = r.flag_a_n;
   assign link.tone_flag_b_n = r.flag_b_n;
   assign link.dev_io_o = r.io_o;
   assign link.dev_io_oe_n = r.io_oe_n;
   assign ctl_mode = r.ctl;
   assign standby = r.stby;
   assign suppressor_en = r.supp;
   assign phase_strict = r.phase;
   assign alaw_sel = r.alaw;
   assign itu_code = r.itu;
   assign state_a = r.sa;
   assign state_b = r.sb;
endmodule // ecpc_dev
`default_nettype wire

// ==== core/ecpc_host.sv ====
/*
 host end: apb slave holding strap levels and a microport command, and the
 serial master that makes sclk by dividing pclk.
 assumes the device resolves frames as 8 command bits then 8 data bits, msb first.
*/
`timescale 1ns/1ps
`default_nettype none
module ecpc_host import ecpc_pkg::*; #(
   parameter bit SHARED_DATA = 1'b0,
   parameter int SCLK_HALF = ECPC_SCLK_HALF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   ecpc_link_if.host link
);
   ecpc_host_reg_t r;
   ecpc_host_reg_t next_r;
   logic [2:0] sy;
   logic ctl;
   logic busy;
   logic hit;
   logic half_end;
   initial begin
      // sync delay must fit inside one sclk half
      if (SCLK_HALF < 6 || SCLK_HALF > 255) $error("ecpc_host: SCLK_HALF out of range");
   end
   ecpc_sync #(.W(3)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({link.tone_flag_b_n, link.tone_flag_a_n, link.state_sel_a_lo}),
      .q(sy)
   );
   // ****************************************
   // apb and serial master
   // ****************************************
   always_comb begin
      next_r = r;
      busy = (r.st != ecpc_idle);
      hit = psel & penable & ~r.ack;
      half_end = (r.div == 8'(SCLK_HALF - 1));
      // one wait state keeps prdata and pslverr in flops
      next_r.ack = hit;
      if (hit) begin
         next_r.prdata = 32'h0000_0000;
         next_r.err = 1'b0;
         if (paddr == ECPC_APB_STRAP) begin
            next_r.prdata = {21'h000000, r.strap};
         end else if (paddr == ECPC_APB_CMD) begin
            next_r.prdata = {16'h0000, r.sh};
         end else if (paddr == ECPC_APB_STAT) begin
            next_r.prdata = {14'h0000, ~sy[2], ~sy[1], r.rd, 7'h00, busy};
         end else begin
            next_r.err = 1'b1;
         end
      end
      case (r.st)
         ecpc_idle: begin
            next_r.cs_n = 1'b1;
            next_r.sclk = 1'b0;
            next_r.div = 8'h00;
            if (psel && penable && r.ack && pwrite && paddr == ECPC_APB_CMD) begin
               next_r.st = ecpc_xfer;
               next_r.cs_n = 1'b0;
               next_r.sh = pwdata[15:0];
               next_r.rw = pwdata[15];
               next_r.bitn = 5'h00;
            end
         end
         ecpc_xfer: begin
            next_r.div = r.div + 8'h01;
            if (half_end) begin
               next_r.div = 8'h00;
               if (!r.sclk) begin
                  next_r.sclk = 1'b1;
               end else begin
                  next_r.sclk = 1'b0;
                  next_r.sh = {r.sh[14:0], 1'b0};
                  // read bit taken at the end of the high half: the trip through both
                  // synchronisers outlasts one half period
                  if (r.rw && r.bitn >= ECPC_CMD_BITS) begin
                     next_r.rd = {r.rd[6:0], sy[0]};
                  end
                  if (r.bitn == ECPC_FRAME_BITS - 5'h01) begin
                     next_r.st = ecpc_gap;
                     next_r.cs_n = 1'b1;
                  end else begin
                     next_r.bitn = r.bitn + 5'h01;
                  end
               end
            end
         end
         ecpc_gap: begin
            next_r.div = r.div + 8'h01;
            if (half_end) begin
               next_r.div = 8'h00;
               next_r.st = ecpc_idle;
            end
         end
         default: begin
            next_r.st = ecpc_idle;
         end
      endcase
      if (psel && penable && r.ack && pwrite && paddr == ECPC_APB_STRAP) begin
         next_r.strap = pwdata[10:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= ECPC_HOST_RESET;
      end else begin
         r <= next_r;
      end
   end
   // ****************************************
   // pin mux
   // ****************************************
   assign ctl = ~r.strap[ECPC_SB_CFG1] & ~r.strap[ECPC_SB_CFG2];
   assign prdata = r.prdata;
   assign pready = psel & penable & r.ack;
   assign pslverr = psel & penable & r.ack & r.err;
   assign link.cfg_strap_one = r.strap[ECPC_SB_CFG1];
   assign link.cfg_strap_two = r.strap[ECPC_SB_CFG2];
   assign link.suppressor_ctl = r.strap[ECPC_SB_SUPP];
   assign link.tone_phase_strict = r.strap[ECPC_SB_PHASE];
   assign link.law_sel = r.strap[ECPC_SB_LAW];
   assign link.code_style = r.strap[ECPC_SB_STYLE];
   assign link.standby_n = r.strap[ECPC_SB_STBY];
   assign link.state_sel_b_hi = ctl ? r.sclk : r.strap[ECPC_SB_B_HI];
   assign link.state_sel_b_lo = ctl ? r.cs_n : r.strap[ECPC_SB_B_LO];
   // shared variant ties rx low
   assign link.state_sel_a_hi = ctl ? (SHARED_DATA ? 1'b0 : r.sh[15]) : r.strap[ECPC_SB_A_HI];
   assign link.host_io_o = ctl ? r.sh[15] : r.strap[ECPC_SB_A_LO];
   // release io for the read data half of a shared frame
   assign link.host_io_oe_n = ctl ? ~(SHARED_DATA && r.st == ecpc_xfer &&
                              !(r.rw && r.bitn >= ECPC_CMD_BITS)) : 1'b0;
endmodule // ecpc_host
`default_nettype wire

// ==== core/ecpc_link_if.sv ====
/*
 pin bundle between the canceller pin logic and its host or strap source.
 assumes the testbench connects both modports; the shared data pin is
 resolved here from the two enables, idle level high.
*/
`timescale 1ns/1ps
`default_nettype none
interface ecpc_link_if;
   logic cfg_strap_one;
   logic cfg_strap_two;
   logic suppressor_ctl;
   logic tone_phase_strict;
   logic law_sel;
   logic code_style;
   logic standby_n;
   logic tone_flag_a_n;
   logic tone_flag_b_n;
   logic state_sel_b_hi;
   logic state_sel_b_lo;
   logic state_sel_a_hi;
   logic state_sel_a_lo;
   logic host_io_o;
   logic host_io_oe_n;
   logic dev_io_o;
   logic dev_io_oe_n;
   // device wins a clash so a host slip shows as wrong data, not x
   assign state_sel_a_lo = !dev_io_oe_n ? dev_io_o : (!host_io_oe_n ? host_io_o : 1'b1);
   modport dev (
      input cfg_strap_one, cfg_strap_two, suppressor_ctl, tone_phase_strict, law_sel,
      input code_style, standby_n, state_sel_b_hi, state_sel_b_lo, state_sel_a_hi,
      input state_sel_a_lo,
      output tone_flag_a_n, tone_flag_b_n, dev_io_o, dev_io_oe_n
   );
   modport host (
      output cfg_strap_one, cfg_strap_two, suppressor_ctl, tone_phase_strict, law_sel,
      output code_style, standby_n, state_sel_b_hi, state_sel_b_lo, state_sel_a_hi,
      output host_io_o, host_io_oe_n,
      input state_sel_a_lo, tone_flag_a_n, tone_flag_b_n
   );
endinterface
`default_nettype wire

// ==== core/ecpc_pkg.sv ====
/*
 pin control package: microport register map, host apb map, strap bit order,
 state records and their reset values.
 assumes a 100 mhz pclk shared by both ends.
*/
`default_nettype none
package ecpc_pkg;
   // ****************************************
   // microport registers
   // ****************************************
   localparam logic [6:0] ECPC_REG_STATE = 7'h00;
   localparam logic [6:0] ECPC_REG_STATUS = 7'h01;
   localparam logic [6:0] ECPC_REG_CTRL2 = 7'h02;
   localparam int ECPC_CTRL2_SUPP_OFF = 0;
   localparam int ECPC_CTRL2_PHASE_OFF = 1;
   localparam logic [4:0] ECPC_CMD_BITS = 5'h08;
   localparam logic [4:0] ECPC_FRAME_BITS = 5'h10;
   // ****************************************
   // strap pin order, shared by both ends
   // ****************************************
   localparam int ECPC_SB_CFG1 = 0;
   localparam int ECPC_SB_CFG2 = 1;
   localparam int ECPC_SB_SUPP = 2;
   localparam int ECPC_SB_PHASE = 3;
   localparam int ECPC_SB_LAW = 4;
   localparam int ECPC_SB_STYLE = 5;
   localparam int ECPC_SB_STBY = 6;
   localparam int ECPC_SB_B_HI = 7;
   localparam int ECPC_SB_B_LO = 8;
   localparam int ECPC_SB_A_HI = 9;
   localparam int ECPC_SB_A_LO = 10;
   localparam int ECPC_SB_W = 11;
   // ****************************************
   // host apb map
   // ****************************************
   localparam logic [11:0] ECPC_APB_STRAP = 12'h000;
   localparam logic [11:0] ECPC_APB_CMD = 12'h004;
   localparam logic [11:0] ECPC_APB_STAT = 12'h008;
   localparam logic [10:0] ECPC_STRAP_RESET = 11'h040;
   localparam int ECPC_SCLK_HALF = 8;
   typedef logic [1:0] ecpc_fstate_t;
   typedef enum logic [1:0] {ecpc_idle = 2'b00, ecpc_xfer = 2'b01, ecpc_gap = 2'b10} ecpc_host_st_t;
   typedef struct packed {
      logic ctl;
      logic stby;
      logic supp;
      logic phase;
      logic alaw;
      logic itu;
      ecpc_fstate_t sa;
      ecpc_fstate_t sb;
      logic sclk_q;
      logic [4:0] cnt;
      logic [7:0] cmd;
      logic [7:0] wsh;
      ecpc_fstate_t reg_a;
      ecpc_fstate_t reg_b;
      logic supp_off;
      logic phase_off;
      logic io_o;
      logic io_oe_n;
      logic flag_a_n;
      logic flag_b_n;
   } ecpc_dev_st_t;
   localparam ecpc_dev_st_t ECPC_DEV_RESET =
      '{stby: 1'b1, io_oe_n: 1'b1, flag_a_n: 1'b1, flag_b_n: 1'b1, default: '0};
   typedef struct packed {
      ecpc_host_st_t st;
      logic [7:0] div;
      logic [4:0] bitn;
      logic sclk;
      logic cs_n;
      logic rw;
      logic [15:0] sh;
      logic [7:0] rd;
      logic [10:0] strap;
      logic ack;
      logic err;
      logic [31:0] prdata;
   } ecpc_host_reg_t;
   localparam ecpc_host_reg_t ECPC_HOST_RESET =
      '{st: ecpc_idle, cs_n: 1'b1, strap: ECPC_STRAP_RESET, default: '0};
endpackage
`default_nettype wire

// ==== core/ecpc_sync.sv ====
/*
 three stage input synchroniser with agreement filter.
 assumes inputs are asynchronous to pclk; q moves only when stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module ecpc_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } ecpc_sync_t;
   ecpc_sync_t r;
   ecpc_sync_t next_r;
   initial begin
      if (W < 1) $error("ecpc_sync: W must be at least 1");
   end
   always_comb begin
      next_r = r;
      next_r.s1 = d;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      // s1 feeds only s2, never the filter
      next_r.q = (r.s2 & r.s3) | (r.q & (r.s2 ^ r.s3));
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign q = r.q;
endmodule // ecpc_sync
`default_nettype wire
